/* File: design/mgmt_pkg.sv */
// Purpose: Shared constants and types for the PHY management register bank.
// Assumes: Clause-22 management frames; two PHYs behind one management bus.
// Notes: Bit positions refer to the 16-bit basic control word.
package mgmt_pkg;

	// ----------------------------------------
	// Management addresses
	// ----------------------------------------
	localparam logic [4:0] PHY1_ADDR_RST = 5'h01;
	localparam logic [4:0] PHY_ADDR_STEP = 5'h01;
	localparam logic [7:0] GLOBAL_CTRL13_IDX = 8'h0F;
	localparam int ADDR_FIELD_MSB = 7;
	localparam int ADDR_FIELD_LSB = 3;

	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [4:0] IDX_BASIC_CONTROL = 5'h00;
	localparam logic [4:0] IDX_BASIC_STATUS = 5'h01;
	localparam logic [4:0] IDX_IDENT_HIGH = 5'h02;
	localparam logic [4:0] IDX_IDENT_LOW = 5'h03;
	localparam logic [4:0] IDX_AN_ADVERT = 5'h04;
	localparam logic [4:0] IDX_AN_PARTNER = 5'h05;
	localparam logic [4:0] IDX_CABLE_DIAG = 5'h1D;
	localparam logic [4:0] IDX_SPECIAL = 5'h1F;

	// ----------------------------------------
	// Basic control fields
	// ----------------------------------------
	localparam int BIT_LOOPBACK = 14;
	localparam int BIT_FORCE_100 = 13;
	localparam int BIT_AUTONEG_ENABLE = 12;
	localparam int BIT_POWER_DOWN = 11;
	localparam int BIT_AN_RESTART = 9;
	localparam int BIT_FULL_DUPLEX = 8;
	localparam int BIT_XOVER_ALG = 5;
	localparam int BIT_FORCE_STRAIGHT = 4;
	localparam int BIT_DIS_XOVER = 3;
	localparam int BIT_DIS_FAR_FAULT = 2;
	localparam int BIT_DIS_TX = 1;
	localparam int BIT_DIS_LED = 0;
	localparam logic [15:0] CTRL_RST = 16'h1020;
	localparam logic [15:0] CTRL_STORE_MASK = 16'h793F;

	// ----------------------------------------
	// Alternate host port byte (port regs 29/45)
	// ----------------------------------------
	localparam int ALT_LOOPBACK = 0;
	localparam int ALT_FORCE_STRAIGHT = 1;
	localparam int ALT_DIS_XOVER = 2;
	localparam int ALT_POWER_DOWN = 3;
	localparam int ALT_DIS_FAR_FAULT = 4;
	localparam int ALT_AN_RESTART = 5;
	localparam int ALT_DIS_TX = 6;
	localparam int ALT_DIS_LED = 7;

	// ----------------------------------------
	// Frame timing in management clock bits
	// ----------------------------------------
	localparam logic [5:0] PREAMBLE_LEN = 6'd32;
	localparam logic [5:0] HDR_LAST = 6'd12;
	localparam logic [5:0] DATA_LAST = 6'd17;
	localparam logic [1:0] OP_READ = 2'b10;
	localparam logic [1:0] OP_WRITE = 2'b01;

	typedef enum logic [1:0] {
		M_IDLE,
		M_HDR,
		M_DATA
	} mstate_t;

endpackage : mgmt_pkg

/* File: design/signal_sync.sv */
// Purpose: Two-flop synchroniser for levels from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ns
module signal_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import mgmt_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_t;

	sync_t q;
	sync_t d;

	always_comb begin
		d.s1 = async_in;
		d.s2 = q.s1;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.s2;

endmodule : signal_sync

/* File: design/phy_ctrl_reg.sv */
// Purpose: Basic control word of one PHY, shared by two host mappings.
// Assumes: Both write strobes are single-cycle pulses on sys_clk.
// Notes: Restart is a pulse, never stored, so it reads back as zero.
`timescale 1ns/1ns
module phy_ctrl_reg (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic mii_wr,
	input wire logic [15:0] mii_wdata,
	input wire logic alt_wr,
	input wire logic [7:0] alt_wdata,
	output logic [15:0] ctrl_word,
	output logic [7:0] alt_rdata,
	output logic restart_pulse
);
	import mgmt_pkg::*;

	typedef struct packed {
		logic [15:0] word;
		logic restart;
	} ctrl_t;

	localparam ctrl_t CTRL_Q_RST = '{word: CTRL_RST, restart: 1'b0};

	ctrl_t q;
	ctrl_t d;

	// ----------------------------------------
	// Write merge
	// ----------------------------------------
	// Management write applied last so it wins a same-cycle clash
	always_comb begin
		d = q;
		d.restart = 1'b0;
		if (alt_wr) begin
			d.word[BIT_LOOPBACK] = alt_wdata[ALT_LOOPBACK];
			d.word[BIT_FORCE_STRAIGHT] = alt_wdata[ALT_FORCE_STRAIGHT];
			d.word[BIT_DIS_XOVER] = alt_wdata[ALT_DIS_XOVER];
			d.word[BIT_POWER_DOWN] = alt_wdata[ALT_POWER_DOWN];
			d.word[BIT_DIS_FAR_FAULT] = alt_wdata[ALT_DIS_FAR_FAULT];
			d.word[BIT_DIS_TX] = alt_wdata[ALT_DIS_TX];
			d.word[BIT_DIS_LED] = alt_wdata[ALT_DIS_LED];
			d.restart = alt_wdata[ALT_AN_RESTART];
		end
		if (mii_wr) begin
			d.word = mii_wdata & CTRL_STORE_MASK;
			d.restart = mii_wdata[BIT_AN_RESTART];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			q <= CTRL_Q_RST;
		end else begin
			q <= d;
		end
	end

	assign ctrl_word = q.word;
	assign restart_pulse = q.restart;
	// Alternate mapping view of the same bits
	assign alt_rdata = {q.word[BIT_DIS_LED], q.word[BIT_DIS_TX], 1'b0,
		q.word[BIT_DIS_FAR_FAULT], q.word[BIT_POWER_DOWN], q.word[BIT_DIS_XOVER],
		q.word[BIT_FORCE_STRAIGHT], q.word[BIT_LOOPBACK]};

endmodule : phy_ctrl_reg

/* File: design/phy_mgmt_bank.sv */
// Purpose: Management-bus slave and register bank for two PHYs.
// Assumes: mdc is slow against sys_clk (at least eight sys_clk per mdc).
// Notes: Status-type registers are served by the PHY core via aux ports.
`timescale 1ns/1ns

// How it works
// - After reset the first PHY answers at address 1, second at 2.
// - Both addresses reprogrammable from bits 7:3 of global control 0x0F.
// - Only indices 0 to 5, 0x1D and 0x1F are implemented per PHY.
// - Indices 6 to 0x1C and 0x1E do nothing; reads give zero.
// - Other host ports reach control bits through a different byte mapping.
// - First PHY bit 14 loops port 2 traffic; mirrors port register 29 bit 0.
// - Second PHY bit 14 loops port 1 traffic; mirrors register 45 bit 0.
// - Bit 12 enables auto-negotiation, reset 1; else bits 13, 8 force mode.
// - Writing 1 to bit 9 restarts auto-negotiation; 0 does nothing.
// - Bits 11, 1, 0 power down, stop transmit, stop LEDs; all reset 0.
// - Bit 5 picks the crossover detection algorithm; resets to 1.
// - Bit 4 forces straight wiring, transmitting on the receive pair.
// - Bit 3 set disables automatic crossover; reset value 0.
// - Bit 2 set disables far-end fault detection; reset value 0.
module phy_mgmt_bank #(
	parameter logic [15:0] IDENT_HIGH = 16'h0A5A,
	parameter logic [15:0] IDENT_LOW = 16'h5A50
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic global_ctrl13_wr,
	input wire logic [7:0] global_ctrl13_wdata,
	input wire logic alt_wr,
	input wire logic alt_sel,
	input wire logic [7:0] alt_wdata,
	output logic [7:0] alt_rdata,
	output logic [4:0] aux_index,
	output logic aux_phy,
	output logic aux_wr,
	output logic [15:0] aux_wdata,
	input wire logic [15:0] aux_rdata_p1,
	input wire logic [15:0] aux_rdata_p2,
	output logic [1:0] loopback,
	output logic [1:0] force_100,
	output logic [1:0] autoneg_enable,
	output logic [1:0] power_down,
	output logic [1:0] autoneg_restart,
	output logic [1:0] full_duplex,
	output logic [1:0] crossover_algorithm_select,
	output logic [1:0] force_straight_wiring,
	output logic [1:0] disable_auto_crossover,
	output logic [1:0] disable_far_end_fault,
	output logic [1:0] disable_transmit,
	output logic [1:0] disable_led
);
	import mgmt_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		mgmt_pkg::mstate_t st;
		logic [5:0] cnt;
		logic [12:0] hdr;
		logic [15:0] sh;
		logic hit;
		logic rd;
		logic phy_sel;
		logic oe;
		logic out;
		logic mdc_d;
		logic [4:0] base;
		logic [1:0] mii_wr;
		logic aux_wr;
	} bank_t;

	localparam bank_t BANK_RST = '{st: M_IDLE, base: PHY1_ADDR_RST, default: '0};

	bank_t q;
	bank_t d;

	logic mdc_s;
	logic mdio_s;
	logic rise;
	logic [12:0] hdr_full;
	logic [4:0] addr_p1;
	logic [4:0] addr_p2;
	logic [15:0] ctrl_word [2];
	logic [7:0] alt_rd [2];
	logic [1:0] restart;
	logic [15:0] rd_word;
	logic hdr_frame_ok;
	logic hdr_addr_hit;
	logic hdr_is_read;
	logic [4:0] cur_index;
	logic idx_is_ctrl;
	logic idx_is_aux;
	logic idx_aux_wr;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	signal_sync #(
		.WIDTH(2)
	) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.async_in({mdc, mdio_in}),
		.sync_out({mdc_s, mdio_s})
	);

	// Edges found on the synced clock, never the first stage
	assign rise = mdc_s & ~q.mdc_d;
	assign hdr_full = {q.hdr[11:0], mdio_s};

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	assign addr_p1 = q.base;
	assign addr_p2 = 5'(q.base + PHY_ADDR_STEP);
	assign hdr_addr_hit = (hdr_full[9:5] == addr_p1) || (hdr_full[9:5] == addr_p2);

	// ----------------------------------------
	// Header decode
	// ----------------------------------------
	// Bad start bit or opcode: rest of the frame is ignored, never driven
	assign hdr_frame_ok = hdr_full[12]
		&& (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE);
	assign hdr_is_read = (hdr_full[11:10] == OP_READ);
	assign cur_index = q.hdr[4:0];

	// ----------------------------------------
	// Register index classes
	// ----------------------------------------
	// Unlisted indices fall through with no class
	always_comb begin
		idx_is_ctrl = 1'b0;
		idx_is_aux = 1'b0;
		idx_aux_wr = 1'b0;
		if (cur_index == IDX_BASIC_CONTROL) begin
			idx_is_ctrl = 1'b1;
		end else if (cur_index == IDX_BASIC_STATUS) begin
			idx_is_aux = 1'b1;
		end else if (cur_index == IDX_AN_ADVERT) begin
			idx_is_aux = 1'b1;
			idx_aux_wr = 1'b1;
		end else if (cur_index == IDX_AN_PARTNER) begin
			idx_is_aux = 1'b1;
		end else if (cur_index == IDX_CABLE_DIAG) begin
			idx_is_aux = 1'b1;
			idx_aux_wr = 1'b1;
		end else if (cur_index == IDX_SPECIAL) begin
			idx_is_aux = 1'b1;
			idx_aux_wr = 1'b1;
		end
	end

	// ----------------------------------------
	// Read data select
	// ----------------------------------------
	always_comb begin
		// Taken at the first turnaround bit, once the index is complete
		rd_word = '0;
		if (idx_is_ctrl) begin
			rd_word = ctrl_word[q.phy_sel];
		end else if (cur_index == IDX_IDENT_HIGH) begin
			rd_word = IDENT_HIGH;
		end else if (cur_index == IDX_IDENT_LOW) begin
			rd_word = IDENT_LOW;
		end else if (idx_is_aux) begin
			rd_word = q.phy_sel ? aux_rdata_p2 : aux_rdata_p1;
		end
	end

	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	always_comb begin
		d = q;
		d.mdc_d = mdc_s;
		d.mii_wr = 2'b00;
		d.aux_wr = 1'b0;
		if (global_ctrl13_wr) begin
			d.base = global_ctrl13_wdata[ADDR_FIELD_MSB:ADDR_FIELD_LSB];
		end
		if (rise) begin
			case (q.st)
				M_IDLE: begin
					// Needs a full preamble; a short one is simply not a frame
					if (mdio_s) begin
						if (q.cnt != PREAMBLE_LEN) begin
							d.cnt = 6'(q.cnt + 6'd1);
						end
					end else if (q.cnt == PREAMBLE_LEN) begin
						d.st = M_HDR;
						d.cnt = '0;
					end else begin
						d.cnt = '0;
					end
				end
				M_HDR: begin
					d.hdr = hdr_full;
					d.cnt = 6'(q.cnt + 6'd1);
					if (q.cnt == HDR_LAST) begin
						d.cnt = '0;
						d.rd = hdr_is_read;
						d.phy_sel = (hdr_full[9:5] == addr_p2);
						// Unaddressed frames still run on, so the bit count stays aligned
						d.hit = hdr_frame_ok && hdr_addr_hit;
						d.st = hdr_frame_ok ? M_DATA : M_IDLE;
					end
				end
				M_DATA: begin
					d.cnt = 6'(q.cnt + 6'd1);
					if (q.cnt == 6'd0) begin
						// Second turnaround bit driven low only when addressed
						d.oe = q.hit & q.rd;
						d.out = 1'b0;
						d.sh = rd_word;
					end else if (q.rd) begin
						if (q.cnt == DATA_LAST) begin
							d.oe = 1'b0;
						end else begin
							d.out = q.sh[15];
							d.sh = {q.sh[14:0], 1'b0};
						end
					end else if (q.cnt != 6'd1) begin
						d.sh = {q.sh[14:0], mdio_s};
					end
					if (q.cnt == DATA_LAST) begin
						d.st = M_IDLE;
						d.cnt = '0;
						if (q.hit && !q.rd) begin
							if (idx_is_ctrl) begin
								d.mii_wr[q.phy_sel] = 1'b1;
							end else if (idx_aux_wr) begin
								d.aux_wr = 1'b1;
							end
							// Remaining indices swallow the write
						end
					end
				end
				default: begin
					d.st = M_IDLE;
					d.cnt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			q <= BANK_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Control registers, one per PHY
	// ----------------------------------------
	generate
		for (genvar p = 0; p < 2; p++) begin : g_phy
			phy_ctrl_reg u_ctrl (
				.sys_clk(sys_clk),
				.nrst(nrst),
				.mii_wr(q.mii_wr[p]),
				.mii_wdata(q.sh),
				.alt_wr(alt_wr && (alt_sel == 1'(p))),
				.alt_wdata(alt_wdata),
				.ctrl_word(ctrl_word[p]),
				.alt_rdata(alt_rd[p]),
				.restart_pulse(restart[p])
			);
			assign loopback[p] = ctrl_word[p][BIT_LOOPBACK];
			assign force_100[p] = ctrl_word[p][BIT_FORCE_100];
			assign autoneg_enable[p] = ctrl_word[p][BIT_AUTONEG_ENABLE];
			assign full_duplex[p] = ctrl_word[p][BIT_FULL_DUPLEX];
			assign power_down[p] = ctrl_word[p][BIT_POWER_DOWN];
			assign disable_transmit[p] = ctrl_word[p][BIT_DIS_TX];
			assign disable_led[p] = ctrl_word[p][BIT_DIS_LED];
			assign crossover_algorithm_select[p] = ctrl_word[p][BIT_XOVER_ALG];
			assign force_straight_wiring[p] = ctrl_word[p][BIT_FORCE_STRAIGHT];
			assign disable_auto_crossover[p] = ctrl_word[p][BIT_DIS_XOVER];
			assign disable_far_end_fault[p] = ctrl_word[p][BIT_DIS_FAR_FAULT];
			assign autoneg_restart[p] = restart[p];
		end
	endgenerate

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign alt_rdata = alt_rd[alt_sel];
	assign mdio_out = q.out;
	assign mdio_oe = q.oe;
	assign aux_index = q.hdr[4:0];
	assign aux_phy = q.phy_sel;
	assign aux_wr = q.aux_wr;
	assign aux_wdata = q.sh;

endmodule : phy_mgmt_bank

/* File: sim/mdio_host.sv */
// Purpose: Station controller model for the management bus.
// Assumes: One mdc period is 8 sys_clk; the data line has a pull-up.
// Notes: mdc stands low between frames.
`timescale 1ns/1ns
module mdio_host (
	input wire logic sys_clk,
	input wire logic line,
	output logic mdc,
	output logic drv,
	output logic dout
);
	initial begin
		mdc = 1'b0;
		drv = 1'b0;
		dout = 1'b0;
	end
	task automatic frame(input logic [13:0] hd, input logic [15:0] wd, output logic [17:0] rd);
		logic [63:0] bits;
		bits = {32'hFFFF_FFFF, hd, 2'b10, wd};
		for (int i = 63; i >= 0; i--) begin
			drv <= !hd[11] || i > 17; // Reads release from turnaround on
			dout <= bits[i];
			repeat (4) @(posedge sys_clk);
			rd = {rd[16:0], line};
			mdc <= 1'b1;
			repeat (4) @(posedge sys_clk);
			mdc <= 1'b0;
		end
		drv <= 1'b0;
	endtask : frame
endmodule : mdio_host

/* File: sim/phy_mgmt_bank_asserts.sv */
// Purpose: Port assertions for the management register bank.
// Assumes: mdc is seen directly, 8 sys_clk per bit.
// Notes: Restart pulses assume writes spaced by idle cycles.
`timescale 1ns/1ns
module phy_mgmt_bank_asserts (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic mdc,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire logic alt_wr,
	input wire logic alt_sel,
	input wire logic [7:0] alt_wdata,
	input wire logic [7:0] alt_rdata,
	input wire logic [1:0] loopback,
	input wire logic [1:0] autoneg_enable,
	input wire logic [1:0] autoneg_restart,
	input wire logic [1:0] crossover_algorithm_select,
	input wire logic [1:0] power_down
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic mdc_q;
	logic [4:0] rises_q;
	// ----------------------------------------
	// Drive length, in mdc rises
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		mdc_q <= mdc;
		if (!nrst || !mdio_oe) begin
			rises_q <= 5'h00;
		end else if (mdc && !mdc_q) begin
			rises_q <= rises_q + 5'h01;
		end
	end
	sequence s_alt1;
		alt_wr && !alt_sel;
	endsequence
	sequence s_alt2;
		alt_wr && alt_sel;
	endsequence
	a_ta_low: assert property ($rose(mdio_oe) |-> !mdio_out)
		else $error("turnaround not low");
	a_drive_len: assert property ($fell(mdio_oe) |-> rises_q == 5'h11)
		else $error("drive length wrong");
	a_out_steady: assert property (mdio_oe && !mdc && !$past(mdc) |-> $stable(mdio_out))
		else $error("data moved in low phase");
	a_reset_vals: assert property ($rose(nrst) |-> autoneg_enable == 2'b11
		&& crossover_algorithm_select == 2'b11 && loopback == 2'b00 && power_down == 2'b00)
		else $error("bad reset value");
	a_alt_loop1: assert property (s_alt1 |=> loopback[0] == $past(alt_wdata[0]))
		else $error("first loopback");
	a_alt_loop2: assert property (s_alt2 |=> loopback[1] == $past(alt_wdata[0]))
		else $error("second loopback");
	a_alt_restart: assert property (s_alt1 |=> autoneg_restart[0] == $past(alt_wdata[5]))
		else $error("restart from byte");
	a_restart_once: assert property (|autoneg_restart |=> autoneg_restart == 2'b00)
		else $error("restart too long");
	a_alt_read: assert property (alt_rdata[5] == 1'b0 && alt_rdata[0] == loopback[alt_sel]
		&& alt_rdata[3] == power_down[alt_sel])
		else $error("byte readback");
endmodule : phy_mgmt_bank_asserts
bind phy_mgmt_bank phy_mgmt_bank_asserts chk_u (.sys_clk, .nrst, .mdc, .mdio_out, .mdio_oe,
	.alt_wr, .alt_sel, .alt_wdata, .alt_rdata, .loopback, .autoneg_enable, .autoneg_restart,
	.crossover_algorithm_select, .power_down);

/* File: sim/phy_mgmt_bank_test.sv */
// Purpose: Self-checking bench for the management register bank.
// Assumes: Pull-up on the data line; mdc period 320 ns.
// Notes: Seeded random words plus all-ones and all-zeros corners.
`timescale 1ns/1ns
module phy_mgmt_bank_test;
	import mgmt_pkg::*;
	logic sys_clk, nrst, mdc, drv, dout, mdio_in, mdio_out, mdio_oe, alt_wr, alt_sel;
	logic global_ctrl13_wr, aux_wr, aux_phy;
	logic [7:0] global_ctrl13_wdata, alt_wdata, alt_rdata, rs_cnt;
	logic [4:0] aux_index;
	logic [15:0] aux_wdata, aux_rdata_p1, aux_rdata_p2, last [2];
	logic [21:0] aux_seen;
	logic [17:0] rv;
	logic [1:0] loopback, force_100, autoneg_enable, power_down, autoneg_restart;
	logic [1:0] full_duplex, crossover_algorithm_select, force_straight_wiring;
	logic [1:0] disable_auto_crossover, disable_far_end_fault, disable_transmit, disable_led;
	int fail_count, total_checks;
	// Arbitrary identity values, picked only to be recognisable
	localparam logic [15:0] ID_HIGH = 16'h6B2D;
	localparam logic [15:0] ID_LOW = 16'h9C41;
	assign mdio_in = mdio_oe ? mdio_out : (drv ? dout : 1'b1);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	mdio_host host_u (.sys_clk, .line(mdio_in), .mdc, .drv, .dout);
	phy_mgmt_bank #(.IDENT_HIGH(ID_HIGH), .IDENT_LOW(ID_LOW)) dut_u (.sys_clk, .nrst, .mdc,
		.mdio_in, .mdio_out, .mdio_oe,
		.global_ctrl13_wr, .global_ctrl13_wdata, .alt_wr, .alt_sel, .alt_wdata, .alt_rdata,
		.aux_index, .aux_phy, .aux_wr, .aux_wdata, .aux_rdata_p1, .aux_rdata_p2, .loopback,
		.force_100, .autoneg_enable, .power_down, .autoneg_restart, .full_duplex,
		.crossover_algorithm_select, .force_straight_wiring, .disable_auto_crossover,
		.disable_far_end_fault, .disable_transmit, .disable_led);
	always @(posedge sys_clk) begin
		if (!nrst) begin
			rs_cnt <= 8'h00;
			aux_seen <= 22'h00_0000;
		end else begin
			rs_cnt <= rs_cnt + 8'(autoneg_restart[0]) + 8'(autoneg_restart[1]);
			if (aux_wr) aux_seen <= {aux_phy, aux_index, aux_wdata};
		end
	end
	function automatic logic [15:0] exp_ctrl(input logic [15:0] w);
		return w & 16'h793F; // Stored bits 14:11, 8, 5:0
	endfunction : exp_ctrl
	function automatic logic [15:0] ctrl_out(input int p);
		return {1'b0, loopback[p], force_100[p], autoneg_enable[p], power_down[p], 2'b00,
			full_duplex[p], 2'b00, crossover_algorithm_select[p], force_straight_wiring[p],
			disable_auto_crossover[p], disable_far_end_fault[p], disable_transmit[p],
			disable_led[p]};
	endfunction : ctrl_out
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic mx(input logic [1:0] op, input logic [4:0] pa, ra, input logic [15:0] wd);
		host_u.frame({2'b01, op, pa, ra}, wd, rv);
		repeat (8) @(posedge sys_clk);
	endtask : mx
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (40000) @(posedge sys_clk);
		fail_count++;
		end_sim();
	end
	initial begin
		logic [15:0] w;
		logic [7:0] b, n;
		int p;
		nrst = 1'b0;
		global_ctrl13_wr = 1'b0;
		global_ctrl13_wdata = 8'h00;
		alt_wr = 1'b0;
		alt_sel = 1'b0;
		alt_wdata = 8'h00;
		aux_rdata_p1 = 16'h0000;
		aux_rdata_p2 = 16'h0000;
		fail_count = 0;
		total_checks = 0;
		void'($urandom(32'haa23));
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		for (p = 0; p < 2; p++) begin
			mx(OP_READ, 5'(p + 1), IDX_BASIC_CONTROL, 16'h0000);
			chk(rv, {2'b10, 16'h1020});
		end
		for (int k = 0; k < 6; k++) begin
			p = k % 2;
			w = (k < 2) ? {16{k == 0}} : 16'($urandom);
			n = rs_cnt;
			mx(OP_WRITE, 5'(p + 1), IDX_BASIC_CONTROL, w);
			last[p] = exp_ctrl(w);
			chk(18'(ctrl_out(p)), 18'(last[p]));
			chk(18'(rs_cnt - n), 18'(w[9]));
			mx(OP_READ, 5'(p + 1), IDX_BASIC_CONTROL, 16'h0000);
			chk(rv, {2'b10, last[p]});
		end
		aux_rdata_p2 <= 16'($urandom);
		mx(OP_WRITE, 5'h01, 5'(6 + $urandom % 23), 16'hFFFF);
		mx(OP_READ, 5'h01, 5'h1E, 16'h0000);
		chk(rv, {2'b10, 16'h0000});
		chk(18'(ctrl_out(0)), 18'(last[0]));
		mx(OP_READ, 5'h02, IDX_BASIC_STATUS, 16'h0000);
		chk(rv, {2'b10, aux_rdata_p2});
		aux_rdata_p1 <= 16'($urandom);
		mx(OP_READ, 5'h01, IDX_IDENT_HIGH, 16'h0000);
		chk(rv, {2'b10, ID_HIGH});
		mx(OP_READ, 5'h01, IDX_IDENT_LOW, 16'h0000);
		chk(rv, {2'b10, ID_LOW});
		mx(OP_READ, 5'h01, IDX_CABLE_DIAG, 16'h0000);
		chk(rv, {2'b10, aux_rdata_p1});
		mx(OP_WRITE, 5'h02, IDX_SPECIAL, w);
		chk(18'(aux_seen[15:0]), 18'(w));
		chk(18'(aux_seen[21:16]), 18'({1'b1, IDX_SPECIAL}));
		mx(OP_WRITE, 5'h01, IDX_AN_PARTNER, 16'h0000);
		chk(18'(aux_seen[21:16]), 18'({1'b1, IDX_SPECIAL}));
		mx(OP_WRITE, 5'h05, IDX_BASIC_CONTROL, 16'hFFFF);
		mx(OP_READ, 5'h05, IDX_BASIC_CONTROL, 16'h0000);
		chk(rv, 18'h3_FFFF);
		chk(18'(ctrl_out(1)), 18'(last[1]));
		global_ctrl13_wdata <= 8'h48;
		global_ctrl13_wr <= 1'b1;
		@(posedge sys_clk);
		global_ctrl13_wr <= 1'b0;
		mx(OP_READ, 5'h0A, IDX_BASIC_CONTROL, 16'h0000);
		chk(rv, {2'b10, last[1]});
		mx(OP_READ, 5'h01, IDX_BASIC_CONTROL, 16'h0000);
		chk(rv, 18'h3_FFFF);
		for (int k = 0; k < 4; k++) begin
			b = 8'($urandom);
			alt_sel <= k[0];
			alt_wdata <= b;
			alt_wr <= 1'b1;
			@(posedge sys_clk);
			alt_wr <= 1'b0;
			repeat (2) @(posedge sys_clk);
			chk(18'(alt_rdata), 18'({b[7:6], 1'b0, b[4:0]}));
			mx(OP_READ, 5'(9 + k[0]), IDX_BASIC_CONTROL, 16'h0000);
			w = {1'b0, b[0], 2'b00, b[3], 6'h00, b[1], b[2], b[4], b[6], b[7]};
			chk(18'(rv[15:0] & 16'h481F), 18'(w));
		end
		end_sim();
	end
endmodule : phy_mgmt_bank_test
